// >>> core/adc_input_sequencer.sv
// Purpose: channel selection registers and conversion sequencer
// Assumes: converter core answers each request with a done pulse
// Notes: selection is latched when a sequence starts
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - convert only inputs whose select bit is 1
// - walk low register from bit 14 down
// - then high register bits 14 to 12
// - single-ended result to register n, unsigned
// - pair 0/1 differential into register 0, signed
// - pair 2/3 differential into register 2, signed
// - bits 14/13 override differential bit 12
// - bits 11/10 override differential bit 9
// - pair 0/1 differential only when alone
// - pair 2/3 differential only when alone
// - low bits 8..0 pick inputs 4..12
// - low select at 50h, resets to zero
// - high select at 51h, resets to zero
module adc_input_sequencer
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // converter core
   output conv_req_type conv_req,
   output logic conv_start,
   input wire logic conv_done,
   // result steering to data registers
   output logic [3:0] result_index,
   output logic result_twos,
   output logic seq_busy
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SCAN = 3'b010,
      ST_WAIT = 3'b100
   } seq_state_type;

   seq_state_type state_ff, nxt_state;
   logic [15:0] sel_low_ff;
   logic [15:0] sel_high_ff;
   select_pair_type latched_ff;
   logic [NUM_SLOTS-1:0] slot_en;
   logic [4:0] slot_ff;
   logic continuous_ff;
   logic start_req_ff;
   logic [15:0] seq_count_ff;
   logic plan_ready_ff;
   conv_req_type conv_req_ff;
   logic conv_start_ff;
   logic [3:0] result_index_ff;
   logic result_twos_ff;
   logic seq_busy_ff;

   // bus state
   logic aw_held_ff, w_held_ff;
   logic [9:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic do_write;
   logic [15:0] wmask16;
   logic awready_ff, wready_ff, arready_ff;
   logic nxt_aw_held, nxt_w_held, nxt_bvalid;

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign conv_req = conv_req_ff;
   assign conv_start = conv_start_ff;
   assign result_index = result_index_ff;
   assign result_twos = result_twos_ff;
   assign seq_busy = seq_busy_ff;

   assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign wmask16 = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
   assign nxt_aw_held = (s_axi_awvalid & awready_ff) | (aw_held_ff & ~do_write);
   assign nxt_w_held = (s_axi_wvalid & wready_ff) | (w_held_ff & ~do_write);
   assign nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);

   // readies come from flops: each is the inverse of next cycle's held or pending state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
      end else begin
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
         wready_ff <= ~nxt_w_held & ~nxt_bvalid;
      end
   end

   // address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= 10'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_ff <= 1'b0;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_ff <= 1'b1;
         w_data_ff <= s_axi_wdata;
         w_strb_ff <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         if (aw_addr_ff == OFS_SELECT_LOW || aw_addr_ff == OFS_SELECT_HIGH ||
             aw_addr_ff == OFS_SEQ_CTRL) begin
            bresp_ff <= RESP_OKAY;
         end else begin
            bresp_ff <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // selection registers; bit 15 reads zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_low_ff <= SELECT_LOW_RESET;
         sel_high_ff <= SELECT_HIGH_RESET;
      end else if (do_write) begin
         if (aw_addr_ff == OFS_SELECT_LOW) begin
            sel_low_ff <= (sel_low_ff & ~(wmask16 & SELECT_LOW_WMASK)) |
                          (w_data_ff[15:0] & wmask16 & SELECT_LOW_WMASK);
         end
         if (aw_addr_ff == OFS_SELECT_HIGH) begin
            sel_high_ff <= (sel_high_ff & ~(wmask16 & SELECT_HIGH_WMASK)) |
                           (w_data_ff[15:0] & wmask16 & SELECT_HIGH_WMASK);
         end
      end
   end

   // control: bit 0 one-shot start, bit 1 continuous
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         continuous_ff <= 1'b0;
         start_req_ff <= 1'b0;
      end else begin
         if (do_write && aw_addr_ff == OFS_SEQ_CTRL && w_strb_ff[0]) begin
            continuous_ff <= w_data_ff[1];
            // a start written while one is pending is merged, not lost
            // a start consumed in this same cycle is not re-armed by a write of zero
            start_req_ff <= w_data_ff[0] | (start_req_ff && state_ff != ST_IDLE);
         end else if (state_ff == ST_IDLE && start_req_ff) begin
            start_req_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         arready_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         case (s_axi_araddr)
            OFS_SELECT_LOW: rdata_ff <= {16'h0000, sel_low_ff};
            OFS_SELECT_HIGH: rdata_ff <= {16'h0000, sel_high_ff};
            OFS_SEQ_CTRL: rdata_ff <= {30'h00000000, continuous_ff, 1'b0};
            OFS_SEQ_STATUS: rdata_ff <= {seq_count_ff, 6'h00, slot_ff, 4'h0, seq_busy_ff};
            default: begin
               rdata_ff <= 32'h00000000;
               rresp_ff <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   adc_slot_plan u_plan (
      .aclk(aclk),
      .aresetn(aresetn),
      .sel(latched_ff),
      .slot_en_ff(slot_en)
   );

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start_req_ff || continuous_ff) begin
               nxt_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (!plan_ready_ff) begin
               nxt_state = ST_SCAN;
            end else if (slot_ff >= 5'(NUM_SLOTS)) begin
               nxt_state = ST_IDLE;
            end else if (slot_en[slot_ff]) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (conv_done) begin
               nxt_state = ST_SCAN;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // snapshot of the selection, held until the sequence ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latched_ff <= '0;
         plan_ready_ff <= 1'b0;
      end else if (state_ff == ST_IDLE && nxt_state == ST_SCAN) begin
         latched_ff <= '{low: sel_low_ff, high: sel_high_ff};
         plan_ready_ff <= 1'b0;
      end else begin
         // plan module registers its output, so wait one cycle
         plan_ready_ff <= (state_ff != ST_IDLE);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_ff <= 5'h00;
      end else if (state_ff == ST_IDLE) begin
         slot_ff <= 5'h00;
      end else if (state_ff == ST_SCAN && plan_ready_ff && slot_ff < 5'(NUM_SLOTS)) begin
         if (!slot_en[slot_ff]) begin
            slot_ff <= slot_ff + 5'h01;
         end
      end else if (state_ff == ST_WAIT && conv_done) begin
         slot_ff <= slot_ff + 5'h01;
      end
   end

   // channel request: slots 0..14 map to low bits 14..0, 15..17 to inputs 13..15
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_req_ff <= '0;
         conv_start_ff <= 1'b0;
      end else begin
         conv_start_ff <= 1'b0;
         if (state_ff == ST_SCAN && plan_ready_ff && slot_ff < 5'(NUM_SLOTS) && slot_en[slot_ff]) begin
            conv_start_ff <= 1'b1;
            case (slot_ff)
               5'h00: conv_req_ff <= '{channel: 4'h0, diff: 1'b0};
               5'h01: conv_req_ff <= '{channel: 4'h1, diff: 1'b0};
               5'h02: conv_req_ff <= '{channel: 4'h0, diff: 1'b1};
               5'h03: conv_req_ff <= '{channel: 4'h2, diff: 1'b0};
               5'h04: conv_req_ff <= '{channel: 4'h3, diff: 1'b0};
               5'h05: conv_req_ff <= '{channel: 4'h2, diff: 1'b1};
               default: begin
                  if (slot_ff >= 5'h0F) begin
                     conv_req_ff <= '{channel: 4'(slot_ff - 5'h02), diff: 1'b0};
                  end else begin
                     conv_req_ff <= '{channel: 4'(slot_ff - 5'h02), diff: 1'b0};
                  end
               end
            endcase
         end
      end
   end

   // result destination follows the request that just finished
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_index_ff <= 4'h0;
         result_twos_ff <= 1'b0;
      end else if (state_ff == ST_WAIT && conv_done) begin
         result_index_ff <= conv_req_ff.channel;
         result_twos_ff <= conv_req_ff.diff;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_busy_ff <= 1'b0;
         seq_count_ff <= 16'h0000;
      end else begin
         seq_busy_ff <= (nxt_state != ST_IDLE);
         if (state_ff == ST_SCAN && nxt_state == ST_IDLE) begin
            seq_count_ff <= seq_count_ff + 16'h0001;
         end
      end
   end
endmodule
`default_nettype wire

// >>> common/adc_seq_pkg.sv
// Purpose: shared constants and types for the adc input sequencer
// Assumes: 32-bit axi4-lite register bus, 250 MHz aclk
// Notes: select registers keep a word index; their byte address is four times it
package adc_seq_pkg;
   localparam logic [7:0] IDX_SELECT_LOW = 8'h50;
   localparam logic [7:0] IDX_SELECT_HIGH = 8'h51;
   localparam logic [9:0] OFS_SELECT_LOW = {IDX_SELECT_LOW, 2'b00};
   localparam logic [9:0] OFS_SELECT_HIGH = {IDX_SELECT_HIGH, 2'b00};
   localparam logic [9:0] OFS_SEQ_CTRL = 10'h060;
   localparam logic [9:0] OFS_SEQ_STATUS = 10'h064;
   localparam logic [15:0] SELECT_LOW_RESET = 16'h0000;
   localparam logic [15:0] SELECT_HIGH_RESET = 16'h0000;
   localparam logic [15:0] SELECT_LOW_WMASK = 16'h7FFF;
   localparam logic [15:0] SELECT_HIGH_WMASK = 16'h7FFF;
   localparam int BIT_SE0 = 14;
   localparam int BIT_SE1 = 13;
   localparam int BIT_DF01 = 12;
   localparam int BIT_SE2 = 11;
   localparam int BIT_SE3 = 10;
   localparam int BIT_DF23 = 9;
   localparam int BIT_SE13 = 14;
   localparam int NUM_SLOTS = 18;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [3:0] channel;
      logic diff;
   } conv_req_type;

   typedef struct packed {
      logic [15:0] low;
      logic [15:0] high;
   } select_pair_type;
endpackage

// >>> core/adc_slot_plan.sv
// Purpose: turns the latched selection into an ordered slot mask
// Assumes: inputs are stable for the whole sequence
// Notes: registered output, one cycle late after a change
`timescale 1ns/1ps
`default_nettype none
module adc_slot_plan
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // selection in
   input wire select_pair_type sel,
   // slot enables, index 0 visited first
   output logic [NUM_SLOTS-1:0] slot_en_ff
);
   logic [NUM_SLOTS-1:0] nxt_slot_en;
   logic se01;
   logic se23;

   always_comb begin
      se01 = sel.low[BIT_SE0] | sel.low[BIT_SE1];
      se23 = sel.low[BIT_SE2] | sel.low[BIT_SE3];
      // slot order follows bits 14 down to 0, then high bits 14 down to 12
      for (int i = 0; i < 15; i++) begin
         nxt_slot_en[i] = sel.low[14-i];
      end
      nxt_slot_en[14-BIT_DF01] = sel.low[BIT_DF01] & ~se01;
      nxt_slot_en[14-BIT_DF23] = sel.low[BIT_DF23] & ~se23;
      for (int j = 0; j < 3; j++) begin
         nxt_slot_en[15+j] = sel.high[BIT_SE13-j];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_en_ff <= '0;
      end else begin
         slot_en_ff <= nxt_slot_en;
      end
   end
endmodule
`default_nettype wire

// >>> verification/adc_input_sequencer_assertions.sv
// Purpose: register bus and sequencing checks for the input sequencer
// Assumes: one aclk domain, synchronous active-low reset
// Notes: attached to the design top by bind, observes only
`timescale 1ns/1ps
`default_nettype none
module adc_input_sequencer_assertions
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // read channels
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // converter side
   input wire conv_req_type conv_req,
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic [3:0] result_index,
   input wire logic result_twos,
   input wire logic seq_busy
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [4:0] cur_slot;
   logic [4:0] last_slot_ff;
   logic ar_take;
   // visiting position: each pair slot sits right after its two singles
   assign cur_slot = {1'b0, conv_req.channel} + {3'h0, conv_req.diff, 1'b0}
      + ((conv_req.channel > 4'h1) ? 5'h01 : 5'h00) + ((conv_req.channel > 4'h3) ? 5'h01 : 5'h00);
   assign ar_take = s_axi_arvalid && s_axi_arready;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_slot_ff <= 5'h00;
      end else if (conv_start) begin
         last_slot_ff <= cur_slot + 5'h01;
      end else if (!seq_busy) begin
         last_slot_ff <= 5'h00;
      end
   end
   AST_AR_ANSWER: assert property (ar_take |=> s_axi_rvalid)
      else $error("read data late");
   AST_LOW_RESERVED: assert property (ar_take && s_axi_araddr == OFS_SELECT_LOW
      |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:15] == 17'h00000) else $error("low select read bad");
   AST_HIGH_RESERVED: assert property (ar_take && s_axi_araddr == OFS_SELECT_HIGH
      |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:15] == 17'h00000) else $error("high select read bad");
   AST_START_PULSE: assert property (conv_start |=> !conv_start)
      else $error("start longer than one cycle");
   AST_SLOT_ORDER: assert property (conv_start |-> cur_slot >= last_slot_ff)
      else $error("slot visited out of order");
   AST_PAIR_CHANNEL: assert property (conv_start && conv_req.diff
      |-> conv_req.channel == 4'h0 || conv_req.channel == 4'h2) else $error("pair on wrong channel");
   AST_RESULT_STEER: assert property (conv_done && seq_busy
      |=> {result_index, result_twos} == $past(conv_req)) else $error("result steered wrong");
   AST_RESULT_HOLD: assert property (!conv_done |=> $stable(result_index) && $stable(result_twos))
      else $error("result moved without done");
   AST_BUSY_RUNS: assert property (conv_start |=> seq_busy)
      else $error("busy low during conversion");
endmodule
bind adc_input_sequencer adc_input_sequencer_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .conv_req(conv_req), .conv_start(conv_start), .conv_done(conv_done),
   .result_index(result_index), .result_twos(result_twos), .seq_busy(seq_busy));
`default_nettype wire

// >>> verification/adc_input_sequencer_tb.sv
// Purpose: self-checking bench for the input sequencer
// Assumes: bench answers each conversion start with a done pulse
// Notes: done delay varies per slot so slow and prompt answers both occur
`timescale 1ns/1ps
`default_nettype none
module adc_input_sequencer_tb
   import adc_seq_pkg::*;
;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_done;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_start, result_twos, seq_busy;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, result_index;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   conv_req_type conv_req;
   conv_req_type plan_q[$];
   int n_mismatch = 0;
   int checks = 0;
   adc_input_sequencer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_req,
      .conv_start, .conv_done, .result_index, .result_twos, .seq_busy);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask
   task automatic hang(input string what);
      $display("unexpected %s expected answer seen timeout", what);
      n_mismatch++;
      finish_test();
   endtask
   task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 50) hang("write response");
   endtask
   task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 50) hang("read data");
   endtask
   function automatic void add(input logic [3:0] ch, input logic df);
      plan_q.push_back({ch, df});
   endfunction
   function automatic void make_plan(input logic [15:0] lo, input logic [15:0] hi);
      plan_q = {};
      if (lo[14]) add(4'h0, 1'b0);
      if (lo[13]) add(4'h1, 1'b0);
      if (lo[12] && !lo[14] && !lo[13]) add(4'h0, 1'b1);
      if (lo[11]) add(4'h2, 1'b0);
      if (lo[10]) add(4'h3, 1'b0);
      if (lo[9] && !lo[11] && !lo[10]) add(4'h2, 1'b1);
      for (int i = 8; i >= 0; i--) if (lo[i]) add(4'(12 - i), 1'b0);
      for (int i = 14; i >= 12; i--) if (hi[i]) add(4'(27 - i), 1'b0);
   endfunction
   task automatic reg_test();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(OFS_SELECT_LOW, d, r);
      chk("low reset", 32'h0, d);
      axi_rd(OFS_SELECT_HIGH, d, r);
      chk("high reset", 32'h0, d);
      axi_wr(OFS_SELECT_LOW, 32'hFFFF_FFFF, r);
      chk("low write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_rd(OFS_SELECT_LOW, d, r);
      chk("low bits", 32'h0000_7FFF, d);
      axi_wr(OFS_SELECT_HIGH, 32'hFFFF_FFFF, r);
      chk("high write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_rd(OFS_SELECT_HIGH, d, r);
      chk("high bits", {16'h0000, SELECT_HIGH_WMASK}, d);
      axi_wr(10'h070, 32'hFFFF_FFFF, r);
      chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_rd(10'h070, d, r);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      chk("unmapped data", 32'h0, d);
   endtask
   task automatic run_seq(input logic [15:0] lo, input logic [15:0] hi, input logic mid);
      logic [1:0] r;
      int k;
      int n;
      make_plan(lo, hi);
      axi_wr(OFS_SELECT_LOW, {16'h0000, lo}, r);
      axi_wr(OFS_SELECT_HIGH, {16'h0000, hi}, r);
      axi_wr(OFS_SEQ_CTRL, 32'h0000_0001, r);
      for (k = 0; k < plan_q.size(); k++) begin
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (conv_start !== 1'b1 && n < 200);
         if (conv_start !== 1'b1) hang("conversion start");
         chk("request", {27'h0, plan_q[k]}, {27'h0, conv_req});
         if (k > 0) chk("result", {27'h0, plan_q[k-1]}, {27'h0, result_index, result_twos});
         // a selection written mid-run must not disturb the running plan
         if (mid && k == 0) axi_wr(OFS_SELECT_LOW, 32'h0000_4000, r);
         repeat (k % 3) @(posedge aclk);
         conv_done <= 1'b1;
         @(posedge aclk);
         conv_done <= 1'b0;
      end
      for (n = 0; n < 200 && seq_busy !== 1'b0; n++) @(posedge aclk);
      if (seq_busy !== 1'b0) hang("sequence end");
      if (k > 0) chk("last result", {27'h0, plan_q[k-1]}, {27'h0, result_index, result_twos});
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (conv_start !== 1'b0) chk("extra start", 32'h0, 32'h1);
      end
   endtask
   // continuous mode: two sequences of one input, stopped while the second converts
   task automatic cont_test();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      axi_wr(OFS_SELECT_LOW, 32'h0000_0001, r);
      axi_wr(OFS_SELECT_HIGH, 32'h0000_0000, r);
      axi_wr(OFS_SEQ_CTRL, 32'h0000_0002, r);
      chk("ctrl write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (conv_start !== 1'b1 && n < 200);
         if (conv_start !== 1'b1) hang("repeat start");
         chk("repeat request", {27'h0, 4'hC, 1'b0}, {27'h0, conv_req});
         if (k == 0) begin
            axi_rd(OFS_SEQ_CTRL, d, r);
            chk("ctrl readback", 32'h0000_0002, d);
         end else begin
            axi_wr(OFS_SEQ_CTRL, 32'h0000_0000, r);
         end
         conv_done <= 1'b1;
         @(posedge aclk);
         conv_done <= 1'b0;
      end
      for (n = 0; n < 200 && seq_busy !== 1'b0; n++) @(posedge aclk);
      if (seq_busy !== 1'b0) hang("repeat end");
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (conv_start !== 1'b0) chk("stopped start", 32'h0, 32'h1);
      end
      // eight sequences have run by now, idle so slot and busy read zero
      axi_rd(OFS_SEQ_STATUS, d, r);
      chk("status", 32'h0008_0000, d);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_done} = 7'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      reg_test();
      run_seq(16'h7FFF, 16'h7000, 1'b0);
      run_seq(16'h1200, 16'h0000, 1'b0);
      run_seq(16'h3A00, 16'h1000, 1'b0);
      run_seq(16'h2500, 16'h0000, 1'b0);
      run_seq(16'h4201, 16'h2000, 1'b1);
      run_seq(16'h0000, 16'h0000, 1'b0);
      cont_test();
      finish_test();
   end
endmodule
`default_nettype wire
